// *** hdl/adcct_pkg.sv ***
// adcct_pkg: constants and types for the converter sequencing block
// assumes one 125 MHz system clock; master clock arrives as a pin
package adcct_pkg;

    // master clock periods per sequence
    localparam int          CONV_MCLKS      = 18;
    localparam int          CAL_FULL_MCLKS  = 125013;
    localparam int          CAL_DACFS_MCLKS = 111124;
    localparam int          CAL_OFFS_MCLKS  = 13889;
    // result lands one whole period before busy falls (needs half)
    localparam int          LOAD_AT_MCLK    = CONV_MCLKS - 1;
    localparam int          CNT_W           = 17;
    localparam int          RES_W           = 12;
    localparam int          DATA_W          = 16;

    // control word written over the parallel port
    localparam int          CAL_START_BIT   = 4;
    localparam int          CAL_SEL_LSB     = 2;
    localparam logic [1:0]  CAL_SEL_FULL    = 2'h0;
    localparam logic [1:0]  CAL_SEL_DACFS   = 2'h1;
    localparam logic [1:0]  CAL_SEL_OFFS    = 2'h2;

    // reset values
    localparam logic [RES_W-1:0]  RESULT_RST = 12'h000;
    localparam logic [DATA_W-1:0] DATA_RST   = 16'h0000;

    // synchroniser bit positions
    localparam int          PIN_MCLK        = 4;
    localparam int          PIN_CVST        = 3;
    localparam int          PIN_CS          = 2;
    localparam int          PIN_WR          = 1;
    localparam int          PIN_RD          = 0;
    localparam int          PIN_N           = 5;

    typedef enum logic [1:0]
    {
        MODE_CONV,
        MODE_CAL_FULL,
        MODE_CAL_DACFS,
        MODE_CAL_OFFS
    } adcct_mode_t;

    typedef enum logic
    {
        ST_IDLE,
        ST_BUSY
    } adcct_state_t;

endpackage : adcct_pkg

// *** hdl/adcct_res_if.sv ***
// adcct_res_if: link between sequencer and result store
// assumes both ends on the same clock
`timescale 1ns/1ps
interface adcct_res_if;
    import adcct_pkg::*;
    logic                 load;
    logic [RES_W-1:0]     wdata;
    logic                 hi_sel;
    logic [DATA_W-1:0]    rdata;

    modport core  (output load, output wdata, output hi_sel, input rdata);
    modport store (input load, input wdata, input hi_sel, output rdata);
endinterface : adcct_res_if

// *** hdl/adcct_result_store.sv ***
// adcct_result_store: output register holding the last result
// assumes sequencer pulses load once per finished conversion
`timescale 1ns/1ps
module adcct_result_store
    import adcct_pkg::*;
(
    // clock and reset
    input  wire logic    clock_i,
    input  wire logic    sys_rst_i,
    // sequencer side
    adcct_res_if.store   res
);

    typedef struct packed
    {
        logic [RES_W-1:0]  result;
        logic [DATA_W-1:0] rdata;
    } adcct_store_t;

    adcct_store_t q;
    adcct_store_t d;

    always_comb
    begin
        d = q;
        if (res.load)
        begin
            d.result = res.wdata;
        end
        // upper byte moves to the low lanes for byte-wide hosts
        if (res.hi_sel)
        begin
            d.rdata = {8'h00, 4'h0, q.result[RES_W-1:8]};
        end
        else
        begin
            d.rdata = {4'h0, q.result};
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            q <= '{result: RESULT_RST, rdata: DATA_RST};
        end
        else
        begin
            q <= d;
        end
    end

    assign res.rdata = q.rdata;

endmodule : adcct_result_store

// *** hdl/adcct_top.sv ***
// adcct_top: conversion and calibration sequencer with parallel read port
// assumes master clock far slower than clock_i; all pins are asynchronous
// Function
// - conversion lasts exactly eighteen master clocks
// - full self-calibration lasts 125013 master clocks
// - DAC plus full-scale calibration: 111124 clocks
// - system offset calibration lasts 13889 clocks
// - result loaded one whole period before busy falls
// - busy rises within 2.5 clocks of deselect
`timescale 1ns/1ps
module adcct_top
    import adcct_pkg::*;
#(
    parameter int CAL_FULL_CLKS  = CAL_FULL_MCLKS,
    parameter int CAL_DACFS_CLKS = CAL_DACFS_MCLKS,
    parameter int CAL_OFFS_CLKS  = CAL_OFFS_MCLKS
)
(
    // clock and reset
    input  wire logic              clock_i,
    input  wire logic              sys_rst_i,
    // converter pins
    input  wire logic              master_clock_input_i,
    input  wire logic              convert_start_pin_i,
    input  wire logic [RES_W-1:0]  adc_code_i,
    output logic                   busy_o,
    // parallel host port
    input  wire logic              cs_n_i,
    input  wire logic              rd_n_i,
    input  wire logic              wr_n_i,
    input  wire logic              high_byte_select_i,
    input  wire logic [DATA_W-1:0] data_i,
    output logic [DATA_W-1:0]      data_o,
    output logic                   data_oe_o
);

    typedef struct packed
    {
        logic [PIN_N-1:0]  s1;
        logic [PIN_N-1:0]  s2;
        logic [PIN_N-1:0]  s3;
        logic              hbs_s1;
        logic              hbs_s2;
        logic [DATA_W-1:0] dat_s1;
        logic [DATA_W-1:0] dat_s2;
        adcct_state_t      state;
        adcct_mode_t       mode;
        logic [CNT_W-1:0]  cnt;
        logic              busy;
        logic              cal_pend;
        logic [1:0]        cal_sel;
        logic              load;
        logic [RES_W-1:0]  sample;
        logic              oe;
        logic [DATA_W-1:0] dout;
    } adcct_ctl_t;

    adcct_ctl_t  q;
    adcct_ctl_t  d;
    adcct_res_if res ();

    function automatic logic [CNT_W-1:0] seq_len(adcct_mode_t m);
        case (m)
            MODE_CONV:      seq_len = CNT_W'(CONV_MCLKS);
            MODE_CAL_FULL:  seq_len = CNT_W'(CAL_FULL_CLKS);
            MODE_CAL_DACFS: seq_len = CNT_W'(CAL_DACFS_CLKS);
            default:        seq_len = CNT_W'(CAL_OFFS_CLKS);
        endcase
    endfunction : seq_len

    function automatic adcct_mode_t cal_mode(logic [1:0] sel);
        case (sel)
            CAL_SEL_FULL:  cal_mode = MODE_CAL_FULL;
            CAL_SEL_DACFS: cal_mode = MODE_CAL_DACFS;
            default:       cal_mode = MODE_CAL_OFFS;
        endcase
    endfunction : cal_mode

    logic             mclk_rise;
    logic             cvst_rise;
    logic             cs_rise;
    logic             wr_rise;
    logic [CNT_W-1:0] cnt_nx;

    // edges come from the second and third stages only
    assign mclk_rise = q.s2[PIN_MCLK] & ~q.s3[PIN_MCLK];
    assign cvst_rise = q.s2[PIN_CVST] & ~q.s3[PIN_CVST];
    assign cs_rise   = q.s2[PIN_CS] & ~q.s3[PIN_CS];
    assign wr_rise   = q.s2[PIN_WR] & ~q.s3[PIN_WR] & ~q.s2[PIN_CS];
    assign cnt_nx    = q.cnt + CNT_W'(1);

    always_comb
    begin
        d        = q;
        d.s1     = {master_clock_input_i, convert_start_pin_i, cs_n_i,
                    wr_n_i, rd_n_i};
        d.s2     = q.s1;
        d.s3     = q.s2;
        d.hbs_s1 = high_byte_select_i;
        d.hbs_s2 = q.hbs_s1;
        d.dat_s1 = data_i;
        d.dat_s2 = q.dat_s1;
        d.load   = 1'b0;
        d.sample = adc_code_i;
        d.oe     = ~q.s2[PIN_CS] & ~q.s2[PIN_RD];
        d.dout   = res.rdata;
        // a control write arms calibration; deselect launches it
        if (wr_rise && q.state == ST_IDLE)
        begin
            d.cal_pend = q.dat_s2[CAL_START_BIT];
            d.cal_sel  = q.dat_s2[CAL_SEL_LSB +: 2];
        end
        case (q.state)
            ST_IDLE:
            begin
                d.cnt = '0;
                if (cs_rise && q.cal_pend)
                begin
                    d.state    = ST_BUSY;
                    d.busy     = 1'b1;
                    d.mode     = cal_mode(q.cal_sel);
                    d.cal_pend = 1'b0;
                end
                else if (cvst_rise)
                begin
                    d.state = ST_BUSY;
                    d.busy  = 1'b1;
                    d.mode  = MODE_CONV;
                end
            end
            ST_BUSY:
            begin
                // new starts are ignored until the count completes
                if (mclk_rise)
                begin
                    d.cnt = cnt_nx;
                    if (q.mode == MODE_CONV &&
                        cnt_nx == CNT_W'(LOAD_AT_MCLK))
                    begin
                        d.load = 1'b1;
                    end
                    if (cnt_nx == seq_len(q.mode))
                    begin
                        d.state = ST_IDLE;
                        d.busy  = 1'b0;
                    end
                end
            end
            default:
            begin
                d.state = ST_IDLE;
                d.busy  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            q <= '{s1: '1, s2: '1, s3: '1, hbs_s1: 1'b0, hbs_s2: 1'b0,
                   dat_s1: DATA_RST, dat_s2: DATA_RST, state: ST_IDLE,
                   mode: MODE_CONV, cnt: '0, busy: 1'b0, cal_pend: 1'b0,
                   cal_sel: CAL_SEL_FULL, load: 1'b0, sample: RESULT_RST,
                   oe: 1'b0, dout: DATA_RST};
        end
        else
        begin
            q <= d;
        end
    end

    assign res.load   = q.load;
    assign res.wdata  = q.sample;
    assign res.hi_sel = q.hbs_s2;

    adcct_result_store u_store
    (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .res       (res.store)
    );

    assign busy_o    = q.busy;
    assign data_o    = q.dout;
    assign data_oe_o = q.oe;

    // checking helpers: master edges while busy and since the last load
    logic [CNT_W-1:0] h_edges;
    logic [1:0]       h_since_load;

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i || !busy_o)
        begin
            h_edges <= '0;
        end
        else if (mclk_rise)
        begin
            h_edges <= h_edges + CNT_W'(1);
        end
        if (sys_rst_i || res.load)
        begin
            h_since_load <= 2'h0;
        end
        else if (mclk_rise && h_since_load != 2'h3)
        begin
            h_since_load <= h_since_load + 2'h1;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    chk_conv_length: assert property (
        $fell(busy_o) && q.mode == MODE_CONV |-> h_edges == CNT_W'(CONV_MCLKS))
        else $error("conversion length wrong");
    chk_full_cal_length: assert property (
        $fell(busy_o) && q.mode == MODE_CAL_FULL
        |-> h_edges == CNT_W'(CAL_FULL_CLKS))
        else $error("full calibration length wrong");
    chk_dacfs_cal_length: assert property (
        $fell(busy_o) && q.mode == MODE_CAL_DACFS
        |-> h_edges == CNT_W'(CAL_DACFS_CLKS))
        else $error("dac full-scale calibration length wrong");
    chk_offs_cal_length: assert property (
        $fell(busy_o) && q.mode == MODE_CAL_OFFS
        |-> h_edges == CNT_W'(CAL_OFFS_CLKS))
        else $error("offset calibration length wrong");
    chk_result_before_fall: assert property (
        $fell(busy_o) && q.mode == MODE_CONV |-> h_since_load == 2'h1)
        else $error("result not loaded one period before busy fell");
    chk_cal_launch: assert property (
        !busy_o && cs_rise && q.cal_pend |=> busy_o && q.mode != MODE_CONV)
        else $error("busy did not rise after calibration deselect");
    chk_busy_hold: assert property (
        busy_o && !mclk_rise |=> busy_o)
        else $error("busy fell between master clock edges");
    chk_busy_steady: assert property (
        $rose(busy_o) |-> busy_o [*8])
        else $error("busy did not stay asserted");

    cov_conversion: cover property (
        $fell(busy_o) && q.mode == MODE_CONV);
    cov_calibration: cover property (
        $fell(busy_o) && q.mode != MODE_CONV);
    cov_read: cover property ($rose(data_oe_o));

endmodule : adcct_top

// *** testbench/adcct_host_model.sv ***
// adcct_host_model: host processor on the parallel read/write port
// assumes clock_i is the bench clock; strobes move 1 ns after its edge
`timescale 1ns/1ps
module adcct_host_model
    import adcct_pkg::*;
(
    // clock
    input  wire logic              clock_i,
    // read return
    input  wire logic [DATA_W-1:0] rdata_i,
    input  wire logic              oe_i,
    // bus strobes and write data
    output logic                   cs_n_o,
    output logic                   rd_n_o,
    output logic                   wr_n_o,
    output logic                   hbs_o,
    output logic [DATA_W-1:0]      data_o
);
    // 80 ns between reads, clear of both supply minima
    localparam int GAP_CY = 10;

    initial
    begin
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        hbs_o  = 1'b0;
        data_o = 16'h0000;
    end

    task automatic edge_gap(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : edge_gap

    // launch happens at deselect, so cs stays low past the write strobe
    task automatic write_word(input logic [DATA_W-1:0] w);
        edge_gap(1);
        cs_n_o = 1'b0;
        data_o = w;
        wr_n_o = 1'b0;
        edge_gap(4);
        wr_n_o = 1'b1;
        edge_gap(4);
        cs_n_o = 1'b1;
        // released bus shows nothing useful
        data_o = ~w;
    endtask : write_word

    task automatic read_word(input logic hb, output logic [DATA_W-1:0] got,
                             output logic ok);
        ok  = 1'b0;
        got = 16'h0000;
        edge_gap(1);
        hbs_o = hb;
        edge_gap(1);
        cs_n_o = 1'b0;
        rd_n_o = 1'b0;
        for (int i = 0; i < 10 && !ok; i++)
        begin
            edge_gap(1);
            if (oe_i === 1'b1)
            begin
                got = rdata_i;
                ok  = 1'b1;
            end
        end
        rd_n_o = 1'b1;
        cs_n_o = 1'b1;
        edge_gap(GAP_CY);
    endtask : read_word
endmodule : adcct_host_model

// *** testbench/testbench.sv ***
// testbench: sequencing block with a host model and a free master clock
// assumes short calibration counts set through the top's parameters
`timescale 1ns/1ps
module testbench;
    import adcct_pkg::*;
    localparam int FULL_T = 40;
    localparam int DACFS_T = 30;
    localparam int OFFS_T = 20;
    // master period 80 ns = 10 system cycles
    localparam int MC = 10;
    logic              clock_i = 1'b0;
    logic              sys_rst_i = 1'b1;
    logic              mclk = 1'b0;
    logic              cvst = 1'b0;
    logic [RES_W-1:0]  code = 12'h000;
    logic              cs_n, rd_n, wr_n, hbs, busy, oe;
    logic [DATA_W-1:0] wdata, rdata;
    int                mismatches = 0;
    int                n_tests = 0;

    always #4 clock_i = ~clock_i;
    // master clock moves 1 ns after a system edge, like every other input
    initial #5 forever #40 mclk = ~mclk;

    adcct_top #(.CAL_FULL_CLKS(FULL_T), .CAL_DACFS_CLKS(DACFS_T),
                .CAL_OFFS_CLKS(OFFS_T)) DUT (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .master_clock_input_i(mclk), .convert_start_pin_i(cvst),
        .adc_code_i(code), .busy_o(busy), .cs_n_i(cs_n), .rd_n_i(rd_n),
        .wr_n_i(wr_n), .high_byte_select_i(hbs), .data_i(wdata),
        .data_o(rdata), .data_oe_o(oe));
    adcct_host_model host (
        .clock_i(clock_i), .rdata_i(rdata), .oe_i(oe), .cs_n_o(cs_n),
        .rd_n_o(rd_n), .wr_n_o(wr_n), .hbs_o(hbs), .data_o(wdata));

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    task automatic check_eq(input logic [DATA_W-1:0] got, exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_eq

    task automatic check_range(input int got, lo, hi);
        n_tests++;
        if (got < lo || got > hi)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h..%h", $time,
                     got, lo, hi);
        end
    endtask : check_range

    // cycles until busy shows lvl; running out ends the run
    task automatic wait_busy(input logic lvl, input int bound, output int c);
        c = 0;
        while (busy !== lvl)
        begin
            if (c >= bound)
            begin
                mismatches++;
                $display("unexpected at %0t: got %h expected %h", $time,
                         busy, lvl);
                tally_and_finish();
            end
            host.edge_gap(1);
            c++;
        end
    endtask : wait_busy

    task automatic read_chk(input logic hb, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] got;
        logic              ok;
        host.read_word(hb, got, ok);
        check_eq({15'h0000, ok}, 16'h0001);
        check_eq(got, exp);
    endtask : read_chk

    task automatic pulse_convert;
        host.edge_gap(1);
        cvst = 1'b1;
        host.edge_gap(3);
        cvst = 1'b0;
    endtask : pulse_convert

    // busy length in system cycles against n master periods
    task automatic busy_run(input int n, rise_max);
        int c;
        wait_busy(1'b1, rise_max, c);
        wait_busy(1'b0, n * MC + 20, c);
        check_range(c, n * MC - 9, n * MC + 4);
    endtask : busy_run

    // busy must stay low for a while
    task automatic quiet_chk;
        logic seen;
        seen = 1'b0;
        repeat (40)
        begin
            host.edge_gap(1);
            if (busy !== 1'b0)
                seen = 1'b1;
        end
        check_eq({15'h0000, seen}, 16'h0000);
    endtask : quiet_chk

    task automatic run_reset;
        check_eq({14'h0000, busy, oe}, 16'h0000);
        check_eq(rdata, 16'h0000);
    endtask : run_reset

    // code flips as busy falls, so a late load would catch the wrong one
    task automatic run_conversion(input logic [RES_W-1:0] val);
        code = val;
        pulse_convert();
        busy_run(CONV_MCLKS, 10);
        code = ~val;
        read_chk(1'b0, {4'h0, val});
        read_chk(1'b1, {12'h000, val[11:8]});
    endtask : run_conversion

    task automatic run_cal(input logic [1:0] sel, input int n);
        host.write_word({11'h000, 1'b1, sel, 2'b00});
        // 2.5 master periods = 25 system cycles after deselect
        busy_run(n, 25);
    endtask : run_cal

    // convert pulse and read during calibration; disarmed write
    task automatic run_refusal(input logic [RES_W-1:0] last);
        int c;
        host.write_word({11'h000, 1'b1, 2'h2, 2'b00});
        wait_busy(1'b1, 25, c);
        pulse_convert();
        read_chk(1'b0, {4'h0, last});
        wait_busy(1'b0, OFFS_T * MC + 20, c);
        // 4 cycles of convert pulse and 15 of the read precede this wait
        check_range(c + 19, OFFS_T * MC - 9, OFFS_T * MC + 4);
        quiet_chk();
        host.write_word({11'h000, 1'b0, 2'h0, 2'b00});
        quiet_chk();
    endtask : run_refusal

    initial
    begin
        repeat (4) @(posedge clock_i);
        #1;
        sys_rst_i = 1'b0;
        run_reset();
        host.edge_gap(3);
        run_conversion(12'hfff);
        run_conversion(12'h5a3);
        run_cal(2'h0, FULL_T);
        run_cal(2'h1, DACFS_T);
        run_cal(2'h2, OFFS_T);
        run_cal(2'h3, OFFS_T);
        run_refusal(12'h5a3);
        run_conversion(12'h000);
        tally_and_finish();
    end
endmodule : testbench
